//--- csdc_pkg.sv
// shared constants, types and helpers for the chip select configuration block
package csdc_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int CSDC_CHANNELS   = 4;
  localparam int CSDC_REG_ADDR_W = 16;
  localparam int CSDC_ADDR_W     = 24;

  // ---------------------------------------------------------------------------
  // register byte offsets, channel 3 first in each list
  // ---------------------------------------------------------------------------
  localparam logic [CSDC_CHANNELS-1:0][15:0] CSDC_OFS_BOTTOM   =
    {16'h00B1, 16'h00AE, 16'h00AB, 16'h00A8};
  localparam logic [CSDC_CHANNELS-1:0][15:0] CSDC_OFS_TOP      =
    {16'h00B2, 16'h00AF, 16'h00AC, 16'h00A9};
  localparam logic [CSDC_CHANNELS-1:0][15:0] CSDC_OFS_CONTROL  =
    {16'h00B3, 16'h00B0, 16'h00AD, 16'h00AA};
  localparam logic [CSDC_CHANNELS-1:0][15:0] CSDC_OFS_PROTOCOL =
    {16'h00F3, 16'h00F2, 16'h00F1, 16'h00F0};
  localparam logic [15:0]                    CSDC_OFS_STATUS   = 16'h00F8;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CSDC_WAIT_LSB     = 5;
  localparam int CSDC_WAIT_MSB     = 7;
  localparam int CSDC_IO_BIT       = 4;
  localparam int CSDC_EN_BIT       = 3;
  localparam int CSDC_MODE_LSB     = 6;
  localparam int CSDC_MODE_MSB     = 7;
  localparam int CSDC_MUX_BIT      = 5;
  localparam int CSDC_LEN_LSB      = 0;
  localparam int CSDC_LEN_MSB      = 3;
  localparam int CSDC_TOP_BYTE_LSB = 16;
  localparam int CSDC_MID_BYTE_LSB = 8;

  // ---------------------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CSDC_BOTTOM_RST    = 8'h00;
  localparam logic [7:0] CSDC_TOP_RST0      = 8'hFF;
  localparam logic [7:0] CSDC_TOP_RST_OTHER = 8'h00;
  localparam logic [7:0] CSDC_CTL_RST0      = 8'hE8;
  localparam logic [7:0] CSDC_CTL_RST_OTHER = 8'h00;
  localparam logic [7:0] CSDC_PROTO_RST     = 8'h02;
  localparam logic [3:0] CSDC_LEN_INVALID   = 4'h0;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CSDC_MODE_NATIVE     = 2'h0,
    CSDC_MODE_MUX_STROBE = 2'h1,
    CSDC_MODE_RW_STROBE  = 2'h2,
    CSDC_MODE_ADDR_ACK   = 2'h3
  } csdc_mode_type;

  typedef struct packed {
    logic [7:0]    range_bottom_byte;
    logic [7:0]    range_top_byte;
    logic [2:0]    wait_count;
    logic          io_type_select;
    logic          select_enable;
    csdc_mode_type bus_mode;
    logic          addr_data_multiplex;
    logic [3:0]    state_length;
  } csdc_cfg_type;

  typedef struct packed {
    logic [2:0]    wait_states;
    csdc_mode_type bus_mode;
    logic          addr_data_multiplex;
    logic [3:0]    state_clocks;
  } csdc_timing_type;

  typedef struct packed {
    logic [CSDC_ADDR_W-1:0] address;
    logic                   mem_request;
    logic                   io_request;
    logic                   ram_hit;
  } csdc_request_type;

  // ---------------------------------------------------------------------------
  // field packing
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] control_byte(input csdc_cfg_type cfg);
    logic [7:0] b;
    b = 8'h00;
    b[CSDC_WAIT_MSB:CSDC_WAIT_LSB] = cfg.wait_count;
    b[CSDC_IO_BIT] = cfg.io_type_select;
    b[CSDC_EN_BIT] = cfg.select_enable;
    return b;
  endfunction

  function automatic logic [7:0] protocol_byte(input csdc_cfg_type cfg);
    logic [7:0] b;
    b = 8'h00;
    b[CSDC_MODE_MSB:CSDC_MODE_LSB] = cfg.bus_mode;
    b[CSDC_MUX_BIT] = cfg.addr_data_multiplex;
    b[CSDC_LEN_MSB:CSDC_LEN_LSB] = cfg.state_length;
    return b;
  endfunction

  // reserved control bits are simply not stored
  function automatic csdc_cfg_type with_control(input csdc_cfg_type cfg,
                                                input logic [7:0]   b);
    csdc_cfg_type c;
    c = cfg;
    c.wait_count     = b[CSDC_WAIT_MSB:CSDC_WAIT_LSB];
    c.io_type_select = b[CSDC_IO_BIT];
    c.select_enable  = b[CSDC_EN_BIT];
    return c;
  endfunction

  // a zero length would stall a bus state machine forever, so it never lands
  function automatic csdc_cfg_type with_protocol(input csdc_cfg_type cfg,
                                                 input logic [7:0]   b);
    csdc_cfg_type c;
    c = cfg;
    c.bus_mode            = csdc_mode_type'(b[CSDC_MODE_MSB:CSDC_MODE_LSB]);
    c.addr_data_multiplex = b[CSDC_MUX_BIT];
    if (b[CSDC_LEN_MSB:CSDC_LEN_LSB] != CSDC_LEN_INVALID) begin
      c.state_length = b[CSDC_LEN_MSB:CSDC_LEN_LSB];
    end
    return c;
  endfunction

  function automatic csdc_cfg_type reset_cfg(input logic first);
    csdc_cfg_type c;
    c = '0;
    c.range_bottom_byte = CSDC_BOTTOM_RST;
    c.range_top_byte    = first ? CSDC_TOP_RST0 : CSDC_TOP_RST_OTHER;
    c = with_control(c, first ? CSDC_CTL_RST0 : CSDC_CTL_RST_OTHER);
    c = with_protocol(c, CSDC_PROTO_RST);
    return c;
  endfunction

  // what the bus state machines actually use for one channel
  function automatic csdc_timing_type timing_of(input csdc_cfg_type cfg);
    csdc_timing_type t;
    t.bus_mode            = cfg.bus_mode;
    t.addr_data_multiplex = cfg.addr_data_multiplex;
    if (cfg.bus_mode == CSDC_MODE_NATIVE) begin
      t.wait_states  = cfg.wait_count;
      t.state_clocks = CSDC_LEN_INVALID;
    end else begin
      t.wait_states  = 3'h0;
      t.state_clocks = cfg.state_length;
    end
    return t;
  endfunction

endpackage

//--- csdc_channel_match.sv
// address match for one chip select channel
`timescale 1ns/1ps

module csdc_channel_match
  import csdc_pkg::*;
(
  input  csdc_cfg_type     cfg,
  input  csdc_request_type request,
  output logic             hit
);

  logic [7:0] top_byte;
  logic [7:0] mid_byte;

  assign top_byte = request.address[CSDC_TOP_BYTE_LSB +: 8];
  assign mid_byte = request.address[CSDC_MID_BYTE_LSB +: 8];

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  always_comb begin
    hit = 1'b0;
    if (cfg.select_enable) begin
      if (cfg.io_type_select) begin
        // the top bound plays no part for I/O
        hit = request.io_request && (mid_byte == cfg.range_bottom_byte);
      end else begin
        // on-chip RAM wins over any external memory select
        hit = request.mem_request && !request.ram_hit
              && (top_byte >= cfg.range_bottom_byte)
              && (top_byte <= cfg.range_top_byte);
      end
    end
  end

endmodule

//--- csdc_chip_select_config.sv
// chip select configuration registers and select decode for four channels
`timescale 1ns/1ps

// How it works
// - memory select top byte at or below upper bound
// - I/O selects ignore the upper bound
// - upper bound resets FFh on 0, else 00h
// - control bits 7:5 give wait states
// - control bit 4 picks memory or I/O
// - control bit 3 enables the select
// - control resets E8h on 0, else 00h
// - protocol bits 7:6 choose bus protocol
// - non-native protocol drops the wait count
// - protocol bit 5 multiplexes address onto data
// - bits 3:0 give state clocks, zero invalid
// - memory select top byte at or above lower bound
// - I/O select when address 15:8 matches bottom
// - native protocol ignores state length
// - on-chip RAM hit suppresses memory select
module csdc_chip_select_config
  import csdc_pkg::*;
(
  input  logic                                  clock,
  input  logic                                  srst,
  input  logic [CSDC_REG_ADDR_W-1:0]            reg_addr,
  input  logic [7:0]                            reg_wdata,
  input  logic                                  reg_write,
  input  logic                                  reg_read,
  output logic [7:0]                            reg_rdata,
  input  csdc_request_type                      request,
  output logic [CSDC_CHANNELS-1:0]              select_n,
  output csdc_timing_type [CSDC_CHANNELS-1:0]   channel_timing,
  output csdc_timing_type                       active_timing,
  output logic                                  active_valid
);

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  csdc_cfg_type               cfg [CSDC_CHANNELS];
  logic [CSDC_CHANNELS-1:0]   hit;
  logic [CSDC_CHANNELS-1:0]   enable_vec;
  logic [7:0]                 next_rdata;
  csdc_timing_type            next_active_timing;
  logic                       next_active_valid;

  // ---------------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    for (int i = 0; i < CSDC_CHANNELS; i++) begin
      if (srst) begin
        cfg[i] <= reset_cfg(i == 0);
      end else if (reg_write) begin
        if (reg_addr == CSDC_OFS_BOTTOM[i]) begin
          cfg[i].range_bottom_byte <= reg_wdata;
        end
        if (reg_addr == CSDC_OFS_TOP[i]) begin
          cfg[i].range_top_byte <= reg_wdata;
        end
        if (reg_addr == CSDC_OFS_CONTROL[i]) begin
          cfg[i] <= with_control(cfg[i], reg_wdata);
        end
        if (reg_addr == CSDC_OFS_PROTOCOL[i]) begin
          cfg[i] <= with_protocol(cfg[i], reg_wdata);
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (reg_read) begin
      for (int i = 0; i < CSDC_CHANNELS; i++) begin
        if (reg_addr == CSDC_OFS_BOTTOM[i]) begin
          next_rdata = cfg[i].range_bottom_byte;
        end
        if (reg_addr == CSDC_OFS_TOP[i]) begin
          next_rdata = cfg[i].range_top_byte;
        end
        if (reg_addr == CSDC_OFS_CONTROL[i]) begin
          next_rdata = control_byte(cfg[i]);
        end
        if (reg_addr == CSDC_OFS_PROTOCOL[i]) begin
          next_rdata = protocol_byte(cfg[i]);
        end
      end
      if (reg_addr == CSDC_OFS_STATUS) begin
        next_rdata = {4'h0, ~select_n};
      end
    end
  end

  // read data follow each read cycle one cycle later and stand as long as the read is held, zero otherwise
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < CSDC_CHANNELS; g++) begin : g_match
    csdc_channel_match u_match (
      .cfg     (cfg[g]),
      .request (request),
      .hit     (hit[g])
    );
    assign enable_vec[g] = cfg[g].select_enable;
  end

  // overlapping ranges assert every matching select; the lowest channel
  // supplies the timing, since only one protocol can run at a time
  always_comb begin
    next_active_timing = timing_of(cfg[0]);
    next_active_valid  = 1'b0;
    for (int i = CSDC_CHANNELS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        next_active_timing = timing_of(cfg[i]);
        next_active_valid  = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      select_n <= '1;
    end else begin
      select_n <= ~hit;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      active_timing <= timing_of(reset_cfg(1'b1));
      active_valid  <= 1'b0;
    end else begin
      active_timing <= next_active_timing;
      active_valid  <= next_active_valid;
    end
  end

  // ---------------------------------------------------------------------------
  // per-channel timing
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    for (int i = 0; i < CSDC_CHANNELS; i++) begin
      if (srst) begin
        channel_timing[i] <= timing_of(reset_cfg(i == 0));
      end else begin
        channel_timing[i] <= timing_of(cfg[i]);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  top_reset_a: assert property (disable iff (1'b0) srst |=>
      cfg[0].range_top_byte == CSDC_TOP_RST0
      && cfg[1].range_top_byte == CSDC_TOP_RST_OTHER
      && cfg[2].range_top_byte == CSDC_TOP_RST_OTHER
      && cfg[3].range_top_byte == CSDC_TOP_RST_OTHER)
    else $error("upper bound reset value wrong");

  ctl_reset_a: assert property (disable iff (1'b0) srst |=>
      control_byte(cfg[0]) == CSDC_CTL_RST0
      && control_byte(cfg[1]) == CSDC_CTL_RST_OTHER
      && control_byte(cfg[2]) == CSDC_CTL_RST_OTHER
      && control_byte(cfg[3]) == CSDC_CTL_RST_OTHER)
    else $error("control reset value wrong");

  reserved_zero_a: assert property (
      reg_read && (reg_addr == CSDC_OFS_PROTOCOL[0] || reg_addr == CSDC_OFS_PROTOCOL[2])
      |=> reg_rdata[4] == 1'b0)
    else $error("protocol reserved bit reads non-zero");

  ctl_reserved_a: assert property (
      reg_read && (reg_addr == CSDC_OFS_CONTROL[1] || reg_addr == CSDC_OFS_CONTROL[2])
      |=> reg_rdata[2:0] == 3'h0)
    else $error("control reserved bits read non-zero");

  top_roundtrip_a: assert property (
      reg_write && reg_addr == CSDC_OFS_TOP[1]
      ##1 reg_read && reg_addr == CSDC_OFS_TOP[1] && !reg_write
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("upper bound write not read back");

  enable_gate_a: assert property (
      (~select_n & ~$past(enable_vec)) == 4'h0)
    else $error("disabled select asserted");

  mem_range_a: assert property (
      !select_n[0] && !$past(cfg[0].io_type_select)
      |-> $past(request.mem_request)
          && $past(request.address[CSDC_TOP_BYTE_LSB +: 8]) <= $past(cfg[0].range_top_byte)
          && $past(request.address[CSDC_TOP_BYTE_LSB +: 8]) >= $past(cfg[0].range_bottom_byte))
    else $error("memory select outside its range");

  io_match_a: assert property (
      !select_n[1] && $past(cfg[1].io_type_select)
      |-> $past(request.io_request)
          && $past(request.address[CSDC_MID_BYTE_LSB +: 8]) == $past(cfg[1].range_bottom_byte))
    else $error("I/O select without matching address");

  ram_block_a: assert property (
      $past(request.ram_hit) && !$past(cfg[2].io_type_select) |-> select_n[2])
    else $error("memory select asserted over on-chip RAM");

  wait_drop_a: assert property (
      channel_timing[0].wait_states
      == (($past(cfg[0].bus_mode) == CSDC_MODE_NATIVE) ? $past(cfg[0].wait_count) : 3'h0))
    else $error("wait count not honoured per protocol");

  length_drop_a: assert property (
      channel_timing[3].bus_mode == CSDC_MODE_NATIVE |-> channel_timing[3].state_clocks == 4'h0)
    else $error("state length leaks in native protocol");

  mode_write_a: assert property (
      reg_write && reg_addr == CSDC_OFS_PROTOCOL[2] |=> ##1
      channel_timing[2].bus_mode == $past(reg_wdata[CSDC_MODE_MSB:CSDC_MODE_LSB], 2)
      && channel_timing[2].addr_data_multiplex == $past(reg_wdata[CSDC_MUX_BIT], 2))
    else $error("protocol fields not applied");

  length_zero_a: assert property (
      reg_write && reg_addr == CSDC_OFS_PROTOCOL[1] && reg_wdata[3:0] == 4'h0
      |=> cfg[1].state_length == $past(cfg[1].state_length))
    else $error("invalid zero state length accepted");

  type_write_a: assert property (
      reg_write && reg_addr == CSDC_OFS_CONTROL[3]
      |=> cfg[3].io_type_select == $past(reg_wdata[CSDC_IO_BIT]))
    else $error("select type not applied");

  top_write_a: assert property (
      reg_write && reg_addr == CSDC_OFS_TOP[0]
      |=> cfg[0].range_top_byte == $past(reg_wdata))
    else $error("upper bound write not applied");

  bottom_write_a: assert property (
      reg_write && reg_addr == CSDC_OFS_BOTTOM[3]
      |=> cfg[3].range_bottom_byte == $past(reg_wdata))
    else $error("lower bound write not applied");

  enable_write_a: assert property (
      reg_write && reg_addr == CSDC_OFS_CONTROL[0]
      |=> cfg[0].select_enable == $past(reg_wdata[CSDC_EN_BIT]))
    else $error("select enable not applied");

  wait_write_a: assert property (
      reg_write && reg_addr == CSDC_OFS_CONTROL[1]
      |=> cfg[1].wait_count == $past(reg_wdata[CSDC_WAIT_MSB:CSDC_WAIT_LSB]))
    else $error("wait count not applied");

  length_write_a: assert property (
      reg_write && reg_addr == CSDC_OFS_PROTOCOL[0] && reg_wdata[3:0] != 4'h0
      |=> cfg[0].state_length == $past(reg_wdata[CSDC_LEN_MSB:CSDC_LEN_LSB]))
    else $error("state length not applied");

  native_wait_a: assert property (
      channel_timing[1].bus_mode != CSDC_MODE_NATIVE |-> channel_timing[1].wait_states == 3'h0)
    else $error("wait count leaks in strobe protocol");

  io_no_mem_a: assert property (
      !select_n[3]
      |-> ($past(cfg[3].io_type_select) ? $past(request.io_request)
                                         : $past(request.mem_request)))
    else $error("select answered the wrong request type");

  valid_match_a: assert property (
      active_valid == (select_n != 4'hF))
    else $error("active flag disagrees with selects");

  mem_select_c: cover property (!select_n[0] && !cfg[0].io_type_select);
  io_select_c: cover property (!select_n[1] && cfg[1].io_type_select);
  strobe_mode_c: cover property (active_valid && active_timing.bus_mode != CSDC_MODE_NATIVE);
  ram_override_c: cover property (request.ram_hit && request.mem_request && cfg[0].select_enable);

endmodule

//--- csdc_select_peer.sv
// behavioural stand-in for the devices behind the four chip selects; it only records which selects went low
`timescale 1ns/1ps

module csdc_select_peer
  import csdc_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     srst,
  input  wire logic [CSDC_CHANNELS-1:0] select_n,
  output logic      [CSDC_CHANNELS-1:0] selected_seen
);
  // a device only reacts while its line is low, so a stray low pulse is remembered until srst
  always_ff @(posedge clock) begin
    if (srst) begin
      selected_seen <= '0;
    end else begin
      selected_seen <= selected_seen | ~select_n;
    end
  end
endmodule

//--- csdc_chip_select_config_bench.sv
// self-checking bench for the chip select configuration block
`timescale 1ns/1ps

module csdc_chip_select_config_bench;
  import csdc_pkg::*;

  logic                                clock;
  logic                                srst;
  logic [CSDC_REG_ADDR_W-1:0]          reg_addr;
  logic [7:0]                          reg_wdata;
  logic                                reg_write;
  logic                                reg_read;
  logic [7:0]                          reg_rdata;
  csdc_request_type                    request;
  logic [CSDC_CHANNELS-1:0]            select_n;
  csdc_timing_type [CSDC_CHANNELS-1:0] channel_timing;
  csdc_timing_type                     active_timing;
  logic                                active_valid;
  logic [CSDC_CHANNELS-1:0]            selected_seen;
  logic [CSDC_CHANNELS-1:0]            hits_seen;
  logic [7:0]                          sh [16];
  int                                  err_total;
  int                                  n_compared;
  int                                  k;

  csdc_chip_select_config dut (
    .clock          (clock),
    .srst           (srst),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_write      (reg_write),
    .reg_read       (reg_read),
    .reg_rdata      (reg_rdata),
    .request        (request),
    .select_n       (select_n),
    .channel_timing (channel_timing),
    .active_timing  (active_timing),
    .active_valid   (active_valid)
  );

  csdc_select_peer peer (
    .clock         (clock),
    .srst          (srst),
    .select_n      (select_n),
    .selected_seen (selected_seen)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ---------------------------------------------------------------------------
  // expectations: shadow index 0-3 bottom, 4-7 top, 8-11 control, 12-15 protocol
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] ofs(input int n);
    if (n >= 12) return 16'h00F0 + 16'(n % 4);
    return 16'h00A8 + 16'(3 * (n % 4)) + 16'(n / 4);
  endfunction

  task automatic init_shadow();
    for (int i = 0; i < 16; i++) sh[i] = 8'h00;
    sh[4] = 8'hFF;
    sh[8] = 8'hE8;
    for (int i = 12; i < 16; i++) sh[i] = 8'h02;
  endtask

  function automatic csdc_timing_type exp_tim(input int ch);
    csdc_timing_type t;
    t.bus_mode            = csdc_mode_type'(sh[12 + ch][7:6]);
    t.addr_data_multiplex = sh[12 + ch][5];
    if (sh[12 + ch][7:6] == 2'h0) begin
      t.wait_states  = sh[8 + ch][7:5];
      t.state_clocks = 4'h0;
    end else begin
      t.wait_states  = 3'h0;
      t.state_clocks = sh[12 + ch][3:0];
    end
    return t;
  endfunction

  function automatic logic [3:0] exp_sel(input csdc_request_type r);
    logic [3:0] s;
    logic [7:0] c;
    s = 4'h0;
    for (int i = 0; i < 4; i++) begin
      c = sh[8 + i];
      if (c[3] && c[4]) begin
        s[i] = r.io_request && r.address[15:8] == sh[i];
      end else if (c[3]) begin
        s[i] = r.mem_request && !r.ram_hit && r.address[23:16] >= sh[i]
               && r.address[23:16] <= sh[4 + i];
      end
    end
    return s;
  endfunction

  // addresses are pulled near the programmed bounds so the edges get exercised
  function automatic csdc_request_type rand_req();
    csdc_request_type r;
    int kind;
    r.address        = 24'($urandom);
    r.address[23:16] = sh[$urandom % 8] + 8'($urandom % 3) - 8'h01;
    r.address[15:8]  = sh[$urandom % 4] + 8'($urandom % 3) - 8'h01;
    kind             = $urandom % 3;
    r.mem_request    = kind == 0;
    r.io_request     = kind == 1;
    r.ram_hit        = ($urandom % 4) == 0;
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask

  // write then read with no gap, for bound registers only
  task automatic wr_rd(input int n, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= ofs(n);
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    sh[n] = d;
    chk("reg_rdata", reg_rdata, d);
  endtask

  task automatic put(input int n, input logic [7:0] d);
    wr(ofs(n), d);
    if (n >= 12) begin
      sh[n][7:5] = d[7:5];
      if (d[3:0] != 4'h0) sh[n][3:0] = d[3:0];
    end else if (n >= 8) begin
      sh[n] = d & 8'hF8;
    end else begin
      sh[n] = d;
    end
  endtask

  task automatic req(input csdc_request_type r);
    logic [3:0] s;
    int low;
    @(posedge clock);
    request <= r;
    @(posedge clock);
    #1;
    s = exp_sel(r);
    hits_seen |= s;
    low = 0;
    for (int i = 3; i >= 0; i--) if (s[i]) low = i;
    chk("select_n", select_n, 4'(~s));
    chk("active_valid", active_valid, |s);
    chk("active_timing", active_timing, exp_tim(low));
    for (int i = 0; i < 4; i++) chk("channel_timing", channel_timing[i], exp_tim(i));
    @(posedge clock);
    request <= '0;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    srst       = 1'b1;
    reg_addr   = '0;
    reg_wdata  = 8'h00;
    reg_write  = 1'b0;
    reg_read   = 1'b0;
    request    = '0;
    hits_seen  = 4'h0;
    err_total  = 0;
    n_compared = 0;
    void'($urandom(87686));
    init_shadow();
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) rd(ofs(i), sh[i]);
    rd(16'h00B4, 8'h00);
    put(12, 8'h40);
    rd(ofs(12), sh[12]);
    put(8, 8'hFF);
    rd(ofs(8), sh[8]);
    put(13, 8'h80);
    rd(ofs(13), sh[13]);
    wr_rd(5, 8'h5A);
    repeat (300) begin
      k = $urandom % 17;
      if (k == 16) begin
        wr(16'h0100, 8'($urandom));
        rd(16'h0100, 8'h00);
      end else begin
        put(k, 8'($urandom));
        rd(ofs(k), sh[k]);
      end
      repeat (3) req(rand_req());
    end
    repeat (2) @(posedge clock);
    #1;
    chk("peer_seen", selected_seen, hits_seen);
    // second reset in mid-run must restore the documented values
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    init_shadow();
    for (int i = 0; i < 16; i++) rd(ofs(i), sh[i]);
    // channel 0 covers every memory address without an on-chip RAM hit after reset; status mirrors the selects
    @(posedge clock);
    request.address     <= 24'h123456;
    request.mem_request <= 1'b1;
    rd(CSDC_OFS_STATUS, 8'h01);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    summarize();
  end
endmodule
